// file: rtl/lpm_regs.svh
// register indices, field positions, reset values and timing counts
// assumes a 10 MHz core clock; included by bare name
`ifndef LPM_REGS_SVH
`define LPM_REGS_SVH

`define LPM_IDX_ERR_CNT     2'h0
`define LPM_IDX_PUMP_LIMIT  2'h1
`define LPM_IDX_EVENT       2'h2

`define LPM_ERR_CNT_RST     4'h0
`define LPM_ERR_CNT_MAX     4'hf
`define LPM_PUMP_LIMIT_RST  14'h03d0
`define LPM_EVENT_RST       8'h00

`define LPM_EV_CRC          0
`define LPM_EV_LOAD_FAIL    1
`define LPM_EV_EMPTY        2
`define LPM_EV_ASSIST_FAIL  3
`define LPM_EV_PUMP_ERR     5
`define LPM_EV_STATUS       6
`define LPM_EV_MANUAL       7

`define LPM_CLK_MHZ         10
`define LPM_MON_TICK_US     1024
`define LPM_TICK_CYCLES     (`LPM_MON_TICK_US * `LPM_CLK_MHZ)

`endif

// file: rtl/lpm_pkg.sv
// types shared by the loader status and pump monitor block
// no constants here; those live in lpm_regs.svh
package lpm_pkg;

   typedef enum logic [1:0] {
      lpm_pump_idle = 2'b00,
      lpm_pump_run  = 2'b01,
      lpm_pump_over = 2'b10
   } lpm_pump_state_t;

   typedef logic [7:0] lpm_event_t;
   typedef logic [1:0] lpm_reg_idx_t;

endpackage

// file: rtl/lpm_pump_timer.sv
// charge pump on-time timer with 1024 us tick prescaler
// assumes pump_on is already synchronised to clk
`timescale 1ns/1ns
`default_nettype none
`include "lpm_regs.svh"

module lpm_pump_timer #(
   parameter int unsigned TICK_CYCLES = `LPM_TICK_CYCLES
) (
   // clock and control
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // monitor
   input  wire logic        pump_on,
   input  wire logic [13:0] limit,
   output logic             expired,
   output logic [14:0]      elapsed
);

   localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

   lpm_pkg::lpm_pump_state_t state_q;
   lpm_pkg::lpm_pump_state_t state_d;
   logic [13:0]              pre_q;
   logic [14:0]              count_q;
   logic                     tick;

   // idle means the pump was off, so a fresh enable starts from zero
   assign tick = pump_on && (state_q != lpm_pkg::lpm_pump_idle) && (pre_q == TICK_LAST);

   always_ff @(posedge clk) begin
      if (srst) begin
         pre_q <= 14'h0000;
      end else if (ce) begin
         if (!pump_on || state_q == lpm_pkg::lpm_pump_idle || pre_q == TICK_LAST) begin
            pre_q <= 14'h0000;
         end else begin
            pre_q <= pre_q + 14'h0001;
         end
      end
   end

   // saturates so a limit of all ones can still be exceeded
   always_ff @(posedge clk) begin
      if (srst) begin
         count_q <= 15'h0000;
      end else if (ce) begin
         if (!pump_on) begin
            count_q <= 15'h0000; // RULE15
         end else if (tick && count_q != 15'h7fff) begin
            count_q <= count_q + 15'h0001; // RULE4
         end
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         lpm_pkg::lpm_pump_idle: begin
            if (pump_on) begin
               state_d = lpm_pkg::lpm_pump_run;
            end
         end
         lpm_pkg::lpm_pump_run: begin
            if (!pump_on) begin
               state_d = lpm_pkg::lpm_pump_idle;
            end else if (count_q > {1'b0, limit}) begin
               state_d = lpm_pkg::lpm_pump_over; // RULE4
            end
         end
         lpm_pkg::lpm_pump_over: begin
            if (!pump_on) begin
               state_d = lpm_pkg::lpm_pump_idle;
            end
         end
         default: begin
            state_d = lpm_pkg::lpm_pump_idle;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= lpm_pkg::lpm_pump_idle;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   assign expired = (state_q == lpm_pkg::lpm_pump_over);
   assign elapsed = count_q;

   a_timer_idle_zero: assert property (@(posedge clk) disable iff (srst) // RULE15
      ce && !pump_on |=> count_q == 15'h0000 && state_q == lpm_pkg::lpm_pump_idle)
      else $error("pump timer not cleared while pump off");

   a_timer_expire: assert property (@(posedge clk) disable iff (srst) // RULE4
      ce && pump_on && state_q == lpm_pkg::lpm_pump_run && count_q > {1'b0, limit}
      |=> expired)
      else $error("pump timer did not expire past limit");

   a_timer_no_early: assert property (@(posedge clk) disable iff (srst) // RULE4
      ce && state_q == lpm_pkg::lpm_pump_run && count_q <= {1'b0, limit}
      |=> !expired)
      else $error("pump timer expired before limit");

endmodule
`default_nettype wire

// file: rtl/lpm_top.sv
// loader checksum error counter, pump monitor limit and fuse event flags
// fuse_status and pump_monitor_active arrive from outside the clk domain;
// loader event pulses are single clk-cycle strobes from same-clock logic
//
// Operation
// RULE1 - each serial-memory checksum error adds one to a 4-bit counter, saturating at 0xf; an error in the same cycle as an accepted counter write is dropped
// RULE2 - writing zero clears the counter; other values preset it
// RULE3 - counter writes ignored while fuse block is clock-gated or in soft reset
// RULE4 - time pump enable in 1024 us ticks against a 14-bit limit
// RULE5 - pump on longer than limit sets event bit 5
// RULE6 - bit 5 clears by writing one only once pump monitor is inactive
// RULE7 - manual request completion sets bit 7; write one clears it
// RULE8 - fuse status output is latched sticky in bit 6; write one clears
// RULE9 - clearing bit 6 while status is still high sets it again at once
// RULE10 - program-assist failure sets bit 3
// RULE11 - empty configuration load sets bit 2; write one clears it
// RULE12 - fuse load failure sets bit 1; write one clears it
// RULE13 - fuse load checksum error sets bit 0; write one clears it
// RULE14 - writing zero leaves flags alone; a same-cycle event beats the clear
// RULE15 - pump timer restarts on each new enable and holds zero while off
`timescale 1ns/1ns
`default_nettype none
`include "lpm_regs.svh"

module lpm_top #(
   parameter int unsigned TICK_CYCLES = `LPM_TICK_CYCLES
) (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   // register port
   input  wire logic [1:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   // loader event strobes
   input  wire logic        mem_crc_err,
   input  wire logic        fuse_crc_err,
   input  wire logic        fuse_load_fail,
   input  wire logic        fuse_config_empty,
   input  wire logic        assist_fail,
   input  wire logic        manual_done,
   // fuse block control
   input  wire logic        fuse_block_clock_gate,
   input  wire logic        fuse_block_soft_reset,
   // fuse array pins
   input  wire logic        fuse_status,
   input  wire logic        pump_monitor_active,
   // status
   output logic             pump_expired
);

   function automatic logic reg_hit(input logic [1:0] addr, input logic [1:0] idx);
      reg_hit = (addr == idx);
   endfunction

   logic [1:0]         pin_raw;
   logic [1:0]         pin_flt;
   logic [3:0]         cnt_q;
   logic [13:0]        limit_q;
   lpm_pkg::lpm_event_t ev_q;
   lpm_pkg::lpm_event_t ev_set;
   lpm_pkg::lpm_event_t ev_clr;
   logic               wr_cnt;
   logic               wr_cnt_ok;
   logic               wr_ev;
   logic               status_f;
   logic               pump_f;
   logic               expired;
   logic [15:0]        rdata_q;

   assign pin_raw = {pump_monitor_active, fuse_status};

   // three stages; the filtered level only moves when stages two and three agree
   for (genvar i = 0; i < 2; i++) begin : g_sync
      logic [2:0] sh_q;
      logic       flt_q;
      always_ff @(posedge clk) begin
         if (srst) begin
            sh_q  <= 3'h0;
            flt_q <= 1'b0;
         end else if (ce) begin
            sh_q <= {sh_q[1:0], pin_raw[i]};
            if (sh_q[2] == sh_q[1]) begin
               flt_q <= sh_q[2];
            end
         end
      end
      assign pin_flt[i] = flt_q;
   end

   assign status_f = pin_flt[0];
   assign pump_f   = pin_flt[1];

   assign wr_cnt    = reg_wr && reg_hit(reg_addr, `LPM_IDX_ERR_CNT);
   assign wr_cnt_ok = wr_cnt && !fuse_block_clock_gate && !fuse_block_soft_reset; // RULE3
   assign wr_ev     = reg_wr && reg_hit(reg_addr, `LPM_IDX_EVENT);

   // a software preset wins over a same-cycle increment
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= `LPM_ERR_CNT_RST;
      end else if (ce) begin
         if (wr_cnt_ok) begin
            cnt_q <= reg_wdata[3:0]; // RULE2
         end else if (mem_crc_err && cnt_q != `LPM_ERR_CNT_MAX) begin
            cnt_q <= cnt_q + 4'h1; // RULE1
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         limit_q <= `LPM_PUMP_LIMIT_RST;
      end else if (ce && reg_wr && reg_hit(reg_addr, `LPM_IDX_PUMP_LIMIT)) begin
         limit_q <= reg_wdata[13:0]; // RULE4
      end
   end

   lpm_pump_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .clk     (clk),
      .srst    (srst),
      .ce      (ce),
      .pump_on (pump_f),
      .limit   (limit_q),
      .expired (expired),
      .elapsed ()
   );

   always_comb begin
      ev_set                      = 8'h00;
      ev_set[`LPM_EV_CRC]         = fuse_crc_err;      // RULE13
      ev_set[`LPM_EV_LOAD_FAIL]   = fuse_load_fail;    // RULE12
      ev_set[`LPM_EV_EMPTY]       = fuse_config_empty; // RULE11
      ev_set[`LPM_EV_ASSIST_FAIL] = assist_fail;       // RULE10
      ev_set[`LPM_EV_PUMP_ERR]    = expired;           // RULE5
      ev_set[`LPM_EV_STATUS]      = status_f;          // RULE8
      ev_set[`LPM_EV_MANUAL]      = manual_done;       // RULE7
   end

   always_comb begin
      ev_clr = wr_ev ? reg_wdata[7:0] : 8'h00; // RULE14
      ev_clr[4] = 1'b0;
      // pump error sticks while the pump is still reported on
      if (pump_f) begin
         ev_clr[`LPM_EV_PUMP_ERR] = 1'b0; // RULE6
      end
   end

   // set is applied after clear, so a new event is never lost
   always_ff @(posedge clk) begin
      if (srst) begin
         ev_q <= `LPM_EVENT_RST;
      end else if (ce) begin
         ev_q <= (ev_q & ~ev_clr) | ev_set; // RULE14 RULE9
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 16'h0000;
      end else if (ce && reg_rd) begin
         if (reg_hit(reg_addr, `LPM_IDX_ERR_CNT)) begin
            rdata_q <= {12'h000, cnt_q};
         end else if (reg_hit(reg_addr, `LPM_IDX_PUMP_LIMIT)) begin
            rdata_q <= {2'h0, limit_q};
         end else if (reg_hit(reg_addr, `LPM_IDX_EVENT)) begin
            rdata_q <= {8'h00, ev_q};
         end else begin
            rdata_q <= 16'h0000;
         end
      end
   end

   assign reg_rdata    = rdata_q;
   assign pump_expired = ev_q[`LPM_EV_PUMP_ERR];

   a_cnt_increment: assert property (@(posedge clk) disable iff (srst) // RULE1
      ce && !wr_cnt_ok && mem_crc_err && cnt_q != 4'hf |=> cnt_q == $past(cnt_q) + 4'h1)
      else $error("checksum counter did not increment");

   a_cnt_saturate: assert property (@(posedge clk) disable iff (srst) // RULE1
      ce && !wr_cnt_ok && cnt_q == 4'hf |=> cnt_q == 4'hf)
      else $error("checksum counter wrapped");

   a_cnt_preset: assert property (@(posedge clk) disable iff (srst) // RULE2
      ce && wr_cnt_ok |=> cnt_q == $past(reg_wdata[3:0]))
      else $error("checksum counter write not taken");

   a_cnt_blocked: assert property (@(posedge clk) disable iff (srst) // RULE3
      ce && wr_cnt && (fuse_block_clock_gate || fuse_block_soft_reset) && !mem_crc_err
      |=> cnt_q == $past(cnt_q))
      else $error("checksum counter written while blocked");

   a_pump_flag_set: assert property (@(posedge clk) disable iff (srst) // RULE5
      ce && expired |=> ev_q[5])
      else $error("pump error flag not set");

   a_pump_flag_hold: assert property (@(posedge clk) disable iff (srst) // RULE6
      ce && ev_q[5] && pump_f |=> ev_q[5])
      else $error("pump error cleared while pump active");

   a_manual_set: assert property (@(posedge clk) disable iff (srst) // RULE7
      ce && manual_done |=> ev_q[7])
      else $error("manual ready flag not set");

   a_status_relatch: assert property (@(posedge clk) disable iff (srst) // RULE9
      ce && status_f ##1 ce && wr_ev && reg_wdata[6] && status_f |=> ev_q[6])
      else $error("latched status not reset by high status");

   a_assist_set: assert property (@(posedge clk) disable iff (srst) // RULE10
      ce && assist_fail |=> ev_q[3])
      else $error("assist failure flag not set");

   a_crc_clear: assert property (@(posedge clk) disable iff (srst) // RULE13
      ce && wr_ev && reg_wdata[0] && !fuse_crc_err |=> !ev_q[0])
      else $error("checksum flag not cleared by write one");

   a_flag_w0_hold: assert property (@(posedge clk) disable iff (srst) // RULE14
      ce && ev_q[1] && !(wr_ev && reg_wdata[1]) |=> ev_q[1])
      else $error("load failure flag lost without clear");

endmodule
`default_nettype wire

// file: tb/lpm_fuse_model.sv
// behavioural fuse array pins: charge pump monitor and status output
// assumes requests from the bench; pins follow them late and off the clock edge
`timescale 1ns/1ns
`default_nettype none

module lpm_fuse_model (
   // clock and requests
   input  wire logic clk,
   input  wire logic pump_req,
   input  wire logic status_req,
   // fuse array pins
   output logic      pump_monitor_active,
   output logic      fuse_status
);
   int         seed = 78933;
   logic [1:0] wait_q = 2'h0;

   initial begin
      pump_monitor_active = 1'b0;
      fuse_status = 1'b0;
   end

   // random lag of 0..3 cycles plus 17 ns so the synchronisers see a true async edge
   always @(posedge clk) begin
      if ({pump_req, status_req} == {pump_monitor_active, fuse_status}) begin
         wait_q <= 2'($random(seed));
      end else if (wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
      end else begin
         pump_monitor_active <= #17 pump_req;
         fuse_status <= #17 status_req;
      end
   end
endmodule

`default_nettype wire

// file: tb/tb_lpm_top.sv
// self-checking bench for the loader status and pump monitor block
// assumes lpm_fuse_model drives the async pins; timer tick shortened to 4 cycles
`timescale 1ns/1ns
`default_nettype none

module tb_lpm_top;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic [1:0]  reg_addr = 2'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic [5:0]  ev = 6'h00;
   logic [1:0]  blk = 2'h0;
   logic        pump_req = 1'b0;
   logic        status_req = 1'b0;
   logic        pump_monitor_active;
   logic        fuse_status;
   logic        pump_expired;
   int          miscompares = 0;
   int          total_checks = 0;
   int          seed = 78933;
   int          n;
   logic [3:0]  cnt;
   logic [13:0] lim;
   int          bmap [5] = '{0, 1, 2, 3, 7};

   always #50 clk = ~clk;

   lpm_top #(.TICK_CYCLES(4)) u_lpm_top (
      .clk(clk), .srst(srst), .ce(ce),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .mem_crc_err(ev[0]), .fuse_crc_err(ev[1]), .fuse_load_fail(ev[2]),
      .fuse_config_empty(ev[3]), .assist_fail(ev[4]), .manual_done(ev[5]),
      .fuse_block_clock_gate(blk[0]), .fuse_block_soft_reset(blk[1]),
      .fuse_status(fuse_status), .pump_monitor_active(pump_monitor_active),
      .pump_expired(pump_expired)
   );

   lpm_fuse_model u_lpm_fuse_model (
      .clk(clk), .pump_req(pump_req), .status_req(status_req),
      .pump_monitor_active(pump_monitor_active), .fuse_status(fuse_status)
   );

   task automatic summarize();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg%0d", a), exp, reg_rdata);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask

   // counter model: saturates rather than wrapping
   function automatic logic [3:0] sat(input int k);
      return (k > 15) ? 4'hf : 4'(k);
   endfunction

   initial begin
      idle(6);
      srst <= 1'b0;
      rd(2'h0, 16'h0000);
      rd(2'h1, 16'h03d0);
      rd(2'h2, 16'h0000);
      rd(2'h3, 16'h0000);
      n = ($random(seed) & 15) + 4;
      repeat (n) pulse(0);
      rd(2'h0, {12'h000, sat(n)});
      // corner: one below the top, two more errors must stop at 0xf
      wr(2'h0, 16'h000e);
      repeat (2) pulse(0);
      rd(2'h0, 16'h000f);
      wr(2'h0, 16'h0000);
      rd(2'h0, 16'h0000);
      cnt = 4'($random(seed)) | 4'h1;
      wr(2'h0, {12'h000, cnt});
      pulse(0);
      rd(2'h0, {12'h000, sat(int'(cnt) + 1)});
      for (int g = 0; g < 2; g++) begin
         blk <= 2'(1 << g);
         wr(2'h0, 16'h0000);
         rd(2'h0, {12'h000, sat(int'(cnt) + 1)});
      end
      blk <= 2'h0;
      // enable low: neither a write nor an error may move the count
      ce <= 1'b0;
      wr(2'h0, 16'h0000);
      pulse(0);
      ce <= 1'b1;
      rd(2'h0, {12'h000, sat(int'(cnt) + 1)});
      wr(2'h3, 16'hffff);
      rd(2'h3, 16'h0000);
      wr(2'h1, 16'hffff);
      rd(2'h1, 16'h3fff);
      for (int i = 1; i < 6; i++) begin
         pulse(i);
         wr(2'h2, 16'h0000);
         rd(2'h2, 16'(1 << bmap[i-1]));
         wr(2'h2, 16'(1 << bmap[i-1]));
         rd(2'h2, 16'h0000);
      end
      // event and clearing write in the same cycle
      pulse(5);
      @(posedge clk);
      ev[5] <= 1'b1;
      reg_addr <= 2'h2;
      reg_wdata <= 16'h0080;
      reg_wr <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
      reg_wr <= 1'b0;
      rd(2'h2, 16'h0080);
      wr(2'h2, 16'h0080);
      status_req <= 1'b1;
      idle(10);
      rd(2'h2, 16'h0040);
      wr(2'h2, 16'h0040);
      rd(2'h2, 16'h0040);
      status_req <= 1'b0;
      idle(10);
      rd(2'h2, 16'h0040);
      wr(2'h2, 16'h0040);
      rd(2'h2, 16'h0000);
      lim = 14'($random(seed) & 3) + 14'h1;
      wr(2'h1, {2'b00, lim});
      pump_req <= 1'b1;
      // last edge before the earliest legal expiry; a >= compare would trip here
      idle(4 * int'(lim) + 11);
      #1;
      chk("pump_expired", 16'h0000, {15'h0000, pump_expired});
      n = 0;
      while (pump_expired !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (pump_expired !== 1'b1) begin
         miscompares++;
         summarize();
      end
      rd(2'h2, 16'h0020);
      wr(2'h2, 16'h0020);
      rd(2'h2, 16'h0020);
      pump_req <= 1'b0;
      idle(10);
      wr(2'h2, 16'h0020);
      rd(2'h2, 16'h0000);
      // a timer that kept its old count would expire at once here
      pump_req <= 1'b1;
      idle(4 * int'(lim) + 4);
      rd(2'h2, 16'h0000);
      pump_req <= 1'b0;
      summarize();
   end
endmodule

`default_nettype wire
